// file: rtl/pag_regs.svh
`ifndef PAG_REGS_SVH
`define PAG_REGS_SVH

// ----------------------------------------------------------------------
// Bus register byte offsets.
// ----------------------------------------------------------------------
`define PAG_OFF_CTRL 12'h000
`define PAG_OFF_STATUS 12'h004
`define PAG_OFF_LEVEL 12'h008
`define PAG_OFF_SEL 12'h00C

// ----------------------------------------------------------------------
// Control register field positions.
// ----------------------------------------------------------------------
`define PAG_CTRL_RUN_BIT 0
`define PAG_CTRL_CLEAR_BIT 1

// ----------------------------------------------------------------------
// Parameter numbers handled by the guard itself, plus two that write selection one leaves writable.
// ----------------------------------------------------------------------
`define PAG_P_WSEL 10'h04D
`define PAG_P_GSEL 10'h0A0
`define PAG_P_GCNT 10'h0AC
`define PAG_P_GREG 10'h0AD
`define PAG_P_GREM 10'h0AE
`define PAG_P_LEVEL 10'h128
`define PAG_P_PWD 10'h129
`define PAG_P_STALL 10'h016
`define PAG_P_RSTSEL 10'h04B

// ----------------------------------------------------------------------
// Setting values and reset values.
// ----------------------------------------------------------------------
`define PAG_V_NONE 14'h270F
`define PAG_V_PNUM_MAX 14'h03E7
`define PAG_V_PWD_MIN 14'h03E8
`define PAG_V_PWD_MAX 14'h270E
`define PAG_V_L99 14'h0063
`define PAG_V_L100 14'h0064
`define PAG_V_L101 14'h0065
`define PAG_V_L106 14'h006A
`define PAG_V_L199 14'h00C7
`define PAG_V_L6 14'h0006
`define PAG_V_WSEL_MAX 14'h0002
`define PAG_RST_LEVEL 14'h270F
`define PAG_RST_GSEL 14'h0000
`define PAG_RST_WSEL 2'h0
`define PAG_GROUP_MAX 5'h10
`define PAG_ERR_LIMIT 3'h5

`endif

// file: rtl/pag_pkg.sv
package pag_pkg;

  // Which party issued a parameter request.
  typedef enum logic {PAG_PANEL, PAG_NETWORK} pag_path_t;

  // Parameter number and parameter setting value.
  typedef logic [9:0] pag_pnum_t;
  typedef logic [13:0] pag_val_t;

endpackage

// file: rtl/pag_guard.sv
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "pag_regs.svh"

// Overview of operation
// - User group holds at most sixteen parameters.
// - Group read selection one restricts panel access and network writes to group.
// - Registration write adds number to group.
// - Removal write deletes number from group.
// - Batch clear value wipes whole group.
// - Other batch clear values do nothing.
// - Write and group selection readable past group restriction; lock level still applies.
// - Selection and maintenance numbers never registrable.
// - Removal reads 9999; writing 9999 does nothing.
// - Lock level accepts only documented values.
// - Lock level zero or hundred trips drive.
// - Level table sets panel and network permissions.
// - Levels 99/199 limit panel access and network writes to group.
// - All restrictions combine; any refusal denies.
// - Lock level and password always accessible; level unwritable while locked.
// - Lock and password writable while running.
// - Four digit value registers the password.
// - No password writes while lock level unset.
// - Password writes of 0/9999 change nothing.
// - Password reads give 9999 while unlocked, else error count or zero.
// - Five errors at strict levels block unlock.
// - Registered password enforces level until unlock.
// - Correct password unlocks; wrong one counts error.
// - Full clear refused while running; wipes all.
module pag_guard (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic req_valid,
  input wire pag_pkg::pag_path_t req_path,
  input wire logic req_write,
  input wire pag_pkg::pag_pnum_t req_param,
  input wire pag_pkg::pag_val_t req_value,
  output logic rsp_valid,
  output logic rsp_grant,
  output logic rsp_internal,
  output pag_pkg::pag_val_t rsp_value,
  output logic rsp_pw_error,
  output logic option_fault_trip,
  output logic lock_active
);

  // ----------------------------------------------------------------------
  // Stored state.
  // ----------------------------------------------------------------------
  logic [1:0] write_selection;
  pag_pkg::pag_val_t group_read_selection;
  pag_pkg::pag_val_t lock_level;
  pag_pkg::pag_val_t password;
  logic [2:0] err_count;
  logic [4:0] group_count;
  logic running;
  logic clear_refused;
  pag_pkg::pag_pnum_t slot_param [0:15];
  logic [15:0] slot_used;

  // ----------------------------------------------------------------------
  // Level permission table.
  // ----------------------------------------------------------------------
  // Returns {panel read, panel write, network read, network write}.
  function automatic logic [3:0] pag_perm(input pag_pkg::pag_val_t base,
                                          input logic in_group);
    logic [3:0] p;
    p = 4'hF;
    case (base)
      14'h0001: p = 4'b1010;
      14'h0002: p = 4'b1011;
      14'h0003: p = 4'b1110;
      14'h0006: p = 4'b1110;
      14'h0004: p = 4'b0010;
      14'h0005: p = 4'b0011;
      `PAG_V_L99: p = in_group ? 4'b1111 : 4'b0010;
      default: p = 4'hF;
    endcase
    return p;
  endfunction

  // ----------------------------------------------------------------------
  // Request decode.
  // ----------------------------------------------------------------------
  wire logic is_net = (req_path == pag_pkg::PAG_NETWORK);
  wire logic p_ws = (req_param == `PAG_P_WSEL);
  wire logic p_gsel = (req_param == `PAG_P_GSEL);
  wire logic p_gcnt = (req_param == `PAG_P_GCNT);
  wire logic p_greg = (req_param == `PAG_P_GREG);
  wire logic p_grem = (req_param == `PAG_P_GREM);
  wire logic p_lvl = (req_param == `PAG_P_LEVEL);
  wire logic p_pwd = (req_param == `PAG_P_PWD);
  wire logic p_maint = p_gcnt | p_greg | p_grem;
  wire logic p_pw = p_lvl | p_pwd;
  wire logic p_int = p_ws | p_gsel | p_maint | p_pw;
  wire logic v_none = (req_value == `PAG_V_NONE);
  wire logic v_pnum = (req_value <= `PAG_V_PNUM_MAX);

  // Parameters that may never enter the group.
  wire logic v_excluded = v_pnum &&
    (req_value[9:0] == `PAG_P_WSEL || req_value[9:0] == `PAG_P_GSEL ||
     req_value[9:0] == `PAG_P_GCNT || req_value[9:0] == `PAG_P_GREG ||
     req_value[9:0] == `PAG_P_GREM);

  // ----------------------------------------------------------------------
  // User group lookup, one comparator pair per slot.
  // ----------------------------------------------------------------------
  logic [15:0] req_hit_vec;
  logic [15:0] val_hit_vec;
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_cmp
      assign req_hit_vec[gi] = slot_used[gi] &&
                               (slot_param[gi] == req_param);
      assign val_hit_vec[gi] = slot_used[gi] && v_pnum &&
                               (slot_param[gi] == req_value[9:0]);
    end
  endgenerate
  wire logic in_group = |req_hit_vec;
  wire logic val_in_group = |val_hit_vec;
  wire logic [15:0] free_vec = ~slot_used;
  // Lowest free slot as a one-hot vector.
  wire logic [15:0] first_free = free_vec & (~free_vec + 16'h0001);
  wire logic group_full = (group_count == `PAG_GROUP_MAX);

  // ----------------------------------------------------------------------
  // Lock level decode.
  // ----------------------------------------------------------------------
  wire logic lvl_hi = (lock_level >= `PAG_V_L100);
  wire pag_pkg::pag_val_t lvl_base =
    lvl_hi ? lock_level - `PAG_V_L100 : lock_level;
  wire logic lvl_strict = (lock_level >= `PAG_V_L101 &&
                           lock_level <= `PAG_V_L106) ||
                          lock_level == `PAG_V_L199;
  wire logic lvl_set = (lock_level != `PAG_V_NONE);
  wire logic [3:0] perm = pag_perm(lvl_base, in_group);
  wire logic lvl_rd_ok = is_net ? perm[1] : perm[3];
  wire logic lvl_wr_ok = is_net ? perm[0] : perm[2];
  wire logic lockout = lvl_strict && (err_count == `PAG_ERR_LIMIT);

  // ----------------------------------------------------------------------
  // Individual restrictions, each of which can deny the access.
  // ----------------------------------------------------------------------
  // Password protection while a password stands, with its own params exempt.
  wire logic lock_ok = !lock_active || p_pw ||
                       (req_write ? lvl_wr_ok : lvl_rd_ok);
  // Group read selection one confines the panel; network reads bypass it.
  wire logic grp_ok = (group_read_selection != 14'h0001) || in_group ||
                      p_ws || p_gsel || p_pw ||
                      (is_net && !req_write);
  wire logic ws_exempt = p_ws | p_gsel | p_pw;
  wire logic ws_ok = !req_write || (write_selection == 2'h2) ||
    ((write_selection == 2'h1) ?
       (ws_exempt || req_param == `PAG_P_STALL ||
        req_param == `PAG_P_RSTSEL) :
       (!running || ws_exempt));
  wire logic net_ws_block = req_write && is_net && p_ws;
  wire logic maint_ok = !req_write || !p_maint ||
                        (group_read_selection == `PAG_RST_GSEL);

  // ----------------------------------------------------------------------
  // Value checks for writes to the guard's own parameters.
  // ----------------------------------------------------------------------
  wire logic v_lvl_ok = (req_value <= `PAG_V_L6) ||
                        (req_value == `PAG_V_L99) ||
                        (req_value >= `PAG_V_L100 &&
                         req_value <= `PAG_V_L106) ||
                        (req_value == `PAG_V_L199) || v_none;
  wire logic v_pwd_code = (req_value >= `PAG_V_PWD_MIN) &&
                          (req_value <= `PAG_V_PWD_MAX);
  wire logic pw_noop = (req_value == 14'h0000) || v_none;
  wire logic reg_ok = v_none ||
    (v_pnum && !v_excluded && (val_in_group || !group_full));
  wire logic wr_accept =
    p_ws ? (req_value <= `PAG_V_WSEL_MAX) :
    p_gsel ? (req_value == 14'h0000 || req_value == 14'h0001 || v_none) :
    p_gcnt ? 1'b1 :
    p_greg ? reg_ok :
    p_grem ? (v_none || v_pnum) :
    p_lvl ? (v_lvl_ok && !lock_active) :
    p_pwd ? (pw_noop || (lvl_set && v_pwd_code)) :
    1'b1;

  // ----------------------------------------------------------------------
  // Bus decode and the full parameter clear command.
  // ----------------------------------------------------------------------
  wire logic apb_setup = psel && !penable;
  wire logic apb_done = psel && penable && pready;
  wire logic sel_ctrl = (paddr == `PAG_OFF_CTRL);
  wire logic sel_status = (paddr == `PAG_OFF_STATUS);
  wire logic sel_level = (paddr == `PAG_OFF_LEVEL);
  wire logic sel_sel = (paddr == `PAG_OFF_SEL);
  wire logic mapped = sel_ctrl | sel_status | sel_level | sel_sel;
  wire logic ctrl_wr = apb_done && pwrite && sel_ctrl;
  wire logic clear_cmd = ctrl_wr && pwdata[`PAG_CTRL_CLEAR_BIT];
  wire logic clear_now = clear_cmd && !running;

  // ----------------------------------------------------------------------
  // Final decision; the clear takes the whole cycle so requests then lose.
  // ----------------------------------------------------------------------
  wire logic gate_ok = grp_ok && ws_ok && lock_ok && maint_ok &&
                       !net_ws_block && !clear_now;
  wire logic grant = gate_ok && (!req_write || wr_accept);
  wire logic do_wr = req_valid && req_write && grant;

  // ----------------------------------------------------------------------
  // Write actions.
  // ----------------------------------------------------------------------
  wire logic grp_add = do_wr && p_greg && !v_none && !val_in_group;
  wire logic grp_rem = do_wr && p_grem && !v_none;
  wire logic grp_batch = do_wr && p_gcnt && v_none;
  wire logic set_lvl = do_wr && p_lvl;
  wire logic fault_set = set_lvl && (req_value == 14'h0000 ||
                                     req_value == `PAG_V_L100);
  wire logic pw_write = do_wr && p_pwd && v_pwd_code;
  wire logic pw_register = pw_write && !lock_active;
  wire logic pw_unlock = pw_write && lock_active && !lockout &&
                         (req_value == password);
  wire logic pw_bad = pw_write && lock_active && !pw_unlock;
  wire logic err_inc = pw_bad && (err_count != `PAG_ERR_LIMIT);

  // ----------------------------------------------------------------------
  // Read values of the guard's own parameters.
  // ----------------------------------------------------------------------
  wire pag_pkg::pag_val_t pw_read =
    !lock_active ? `PAG_V_NONE :
    lvl_strict ? {11'h000, err_count} : 14'h0000;
  wire pag_pkg::pag_val_t int_read =
    p_ws ? {12'h000, write_selection} :
    p_gsel ? group_read_selection :
    p_gcnt ? {9'h000, group_count} :
    p_lvl ? lock_level :
    p_pwd ? pw_read :
    `PAG_V_NONE;

  // ----------------------------------------------------------------------
  // Group slot storage, one slot per generate entry.
  // ----------------------------------------------------------------------
  generate
    for (gi = 0; gi < 16; gi++) begin : g_slot
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          slot_used[gi] <= 1'b0;
          slot_param[gi] <= 10'h000;
        end else if (clear_now || grp_batch) begin
          slot_used[gi] <= 1'b0;
        end else if (grp_add && first_free[gi]) begin
          slot_used[gi] <= 1'b1;
          slot_param[gi] <= req_value[9:0];
        end else if (grp_rem && val_hit_vec[gi]) begin
          slot_used[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Entry count tracks the slots so the full test stays a single compare.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      group_count <= 5'h00;
    end else if (clear_now || grp_batch) begin
      group_count <= 5'h00;
    end else if (grp_add) begin
      group_count <= group_count + 5'h01;
    end else if (grp_rem && val_in_group) begin
      group_count <= group_count - 5'h01;
    end
  end

  // Selection parameters written over the request port.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      write_selection <= `PAG_RST_WSEL;
      group_read_selection <= `PAG_RST_GSEL;
    end else if (clear_now) begin
      write_selection <= `PAG_RST_WSEL;
      group_read_selection <= `PAG_RST_GSEL;
    end else if (do_wr && p_ws) begin
      write_selection <= req_value[1:0];
    end else if (do_wr && p_gsel) begin
      group_read_selection <= req_value;
    end
  end

  // Lock level and the trip it can raise; only a full clear removes it.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_level <= `PAG_RST_LEVEL;
      option_fault_trip <= 1'b0;
    end else if (clear_now) begin
      lock_level <= `PAG_RST_LEVEL;
      option_fault_trip <= 1'b0;
    end else if (set_lvl) begin
      lock_level <= req_value;
      option_fault_trip <= option_fault_trip | fault_set;
    end
  end

  // Password, lock state and unlock error counter.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      password <= `PAG_V_NONE;
      lock_active <= 1'b0;
      err_count <= 3'h0;
    end else if (clear_now || pw_unlock) begin
      password <= `PAG_V_NONE;
      lock_active <= 1'b0;
      err_count <= 3'h0;
    end else if (pw_register) begin
      password <= req_value;
      lock_active <= 1'b1;
    end else if (err_inc) begin
      err_count <= err_count + 3'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Request answer, one cycle after the request.
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp_grant <= 1'b0;
      rsp_internal <= 1'b0;
      rsp_value <= 14'h0000;
      rsp_pw_error <= 1'b0;
    end else begin
      rsp_valid <= req_valid;
      rsp_grant <= req_valid && grant;
      rsp_internal <= req_valid && p_int;
      rsp_value <= (req_valid && !req_write && grant && p_int) ?
                   int_read : 14'h0000;
      rsp_pw_error <= pw_bad;
    end
  end

  // ----------------------------------------------------------------------
  // Bus slave: no wait states, answer registered in the setup cycle.
  // ----------------------------------------------------------------------
  wire logic [31:0] bus_read =
    sel_ctrl ? {30'h0000_0000, 1'b0, running} :
    sel_status ? {20'h0_0000, clear_refused, lockout, option_fault_trip,
                  lock_active, err_count, group_count} :
    sel_level ? {18'h0_0000, lock_level} :
    sel_sel ? {16'h0000, write_selection, group_read_selection} :
    32'h0000_0000;

  // Answer flops; holding pready low in setup keeps outputs registered.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup && !mapped;
      prdata <= (apb_setup && !pwrite) ? bus_read : 32'h0000_0000;
    end
  end

  // Run state and whether the last control write was a refused full clear.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      running <= 1'b0;
      clear_refused <= 1'b0;
    end else if (ctrl_wr) begin
      running <= pwdata[`PAG_CTRL_RUN_BIT];
      clear_refused <= clear_cmd && running;
    end
  end

endmodule

// file: verification/pag_requester.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Panel or network master that issues one parameter request at a time.
// ----------------------------------------------------------------------
module pag_requester (
  input wire logic core_clk,
  output logic req_valid,
  output pag_pkg::pag_path_t req_path,
  output logic req_write,
  output pag_pkg::pag_pnum_t req_param,
  output pag_pkg::pag_val_t req_value,
  input wire logic rsp_grant,
  input wire pag_pkg::pag_val_t rsp_value,
  input wire logic rsp_pw_error
);
  // Idle request fields start at known values.
  initial begin
    req_valid = 1'b0;
    req_path = pag_pkg::PAG_PANEL;
    req_write = 1'b0;
    req_param = 10'h000;
    req_value = 14'h0000;
  end

  // Parameter and value fields flip once the request is gone, so a stale value never passes.
  task automatic xfer(input logic network_path, input logic wr, input int p,
      input int d, output logic g, output logic [13:0] rv, output logic e);
    @(posedge core_clk);
    req_valid <= 1'b1;
    req_path <= pag_pkg::pag_path_t'(network_path);
    req_write <= wr;
    req_param <= 10'(p);
    req_value <= 14'(d);
    @(posedge core_clk);
    req_valid <= 1'b0;
    req_param <= ~req_param;
    req_value <= ~req_value;
    @(posedge core_clk);
    g = rsp_grant;
    rv = rsp_value;
    e = rsp_pw_error;
  endtask
endmodule

// file: verification/pag_guard_sva.sv
`timescale 1ns/1ps
`include "pag_regs.svh"
// ----------------------------------------------------------------------
// Port checker for the parameter access guard.
// ----------------------------------------------------------------------
module pag_guard_sva (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic req_valid,
  input wire logic req_write,
  input wire pag_pkg::pag_pnum_t req_param,
  input wire pag_pkg::pag_val_t req_value,
  input wire logic rsp_valid,
  input wire logic rsp_grant,
  input wire pag_pkg::pag_val_t rsp_value,
  input wire logic rsp_pw_error,
  input wire logic option_fault_trip,
  input wire logic lock_active
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // Every answer pairs with exactly one request one cycle earlier.
  rsp_follow_a: assert property (rsp_valid == $past(req_valid))
    else $error("answer without matching request");
  no_grant_idle_a: assert property (!rsp_valid |-> !rsp_grant
    && !rsp_pw_error) else $error("grant outside an answer");
  refused_blank_a: assert property (rsp_valid && !rsp_grant
    |-> rsp_value == 14'h0000) else $error("refused read shows data");
  // The fault may only come from a level 0 or 100 write request.
  fault_cause_a: assert property ($rose(option_fault_trip)
    |-> $past(req_valid && req_write && req_param == `PAG_P_LEVEL
    && (req_value == 14'h0000 || req_value == `PAG_V_L100)))
    else $error("fault without level write");
  fault_hold_a: assert property (option_fault_trip |=> option_fault_trip
    || $past(psel && penable && pwrite && pready))
    else $error("fault dropped without clear");
  lock_cause_a: assert property ($rose(lock_active) |-> $past(
    req_valid && req_write && req_param == `PAG_P_PWD
    && req_value >= `PAG_V_PWD_MIN && req_value <= `PAG_V_PWD_MAX))
    else $error("lock without password");
  pw_error_a: assert property (rsp_pw_error |-> rsp_grant && $past(
    req_param == `PAG_P_PWD && req_write))
    else $error("password error on other request");
  sel_read_a: assert property (req_valid && !req_write && !lock_active
    && (req_param == `PAG_P_WSEL || req_param == `PAG_P_GSEL)
    |=> rsp_grant) else $error("selection read refused");
  count_range_a: assert property (req_valid && !req_write
    && req_param == `PAG_P_GCNT |=> rsp_value <= 14'h0010)
    else $error("group count too large");
  lock_read_a: assert property (req_valid && !req_write
    && req_param == `PAG_P_LEVEL |=> rsp_grant)
    else $error("lock level read refused");
endmodule

bind pag_guard pag_guard_sva i_pag_guard_sva (
  .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .req_valid(req_valid),
  .req_write(req_write), .req_param(req_param), .req_value(req_value),
  .rsp_valid(rsp_valid), .rsp_grant(rsp_grant), .rsp_value(rsp_value),
  .rsp_pw_error(rsp_pw_error), .option_fault_trip(option_fault_trip),
  .lock_active(lock_active)
);

// file: verification/pag_guard_test.sv
`timescale 1ns/1ps
`include "pag_regs.svh"
module pag_guard_test;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, req_valid, req_write;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic rsp_valid, rsp_grant, rsp_pw_error, option_fault_trip;
  logic lock_active, g, e, er, ri;
  logic [13:0] v;
  pag_pkg::pag_path_t req_path;
  pag_pkg::pag_pnum_t req_param;
  pag_pkg::pag_val_t req_value, rsp_value;
  int n_mismatch = 0;
  int n_compared = 0;
  int seed = 99;
  int grp[$];
  int errs;
  int excl[5] = '{`PAG_P_WSEL, `PAG_P_GSEL, `PAG_P_GCNT, `PAG_P_GREG,
    `PAG_P_GREM};

  pag_guard i_pag_guard (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .req_valid(req_valid), .req_path(req_path), .req_write(req_write),
    .req_param(req_param), .req_value(req_value), .rsp_valid(rsp_valid),
    .rsp_grant(rsp_grant), .rsp_internal(ri), .rsp_value(rsp_value),
    .rsp_pw_error(rsp_pw_error), .option_fault_trip(option_fault_trip),
    .lock_active(lock_active));
  pag_requester i_pag_requester (.core_clk(core_clk),
    .req_valid(req_valid), .req_path(req_path), .req_write(req_write),
    .req_param(req_param), .req_value(req_value), .rsp_grant(rsp_grant),
    .rsp_value(rsp_value), .rsp_pw_error(rsp_pw_error));

  // Free-running 125 MHz clock.
  always #4 core_clk = ~core_clk;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
      input string m);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  task automatic summarize();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Holds the request until pready is seen, bounded so a hang is caught.
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    check(pready, 1, "no pready");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask

  task automatic rq(input logic network_path, input logic wr, input int p,
      input int d);
    i_pag_requester.xfer(network_path, wr, p, d, g, v, e);
  endtask

  task automatic cnt();
    rq(0, 0, `PAG_P_GCNT, 0);
    check(v, grp.size(), "group count");
    check(ri, 1, "internal flag");
  endtask

  // Random parameter outside the guard's own range and the group.
  function automatic int fresh();
    int r;
    do r = {$random(seed)} % 1000;
    while (r inside {grp} || (r > 21 && r < 298));
    return r;
  endfunction

  // Permission of a locked level for path and direction.
  function automatic logic perm(input int k, input logic network_path,
      input logic wr);
    case (k)
      1: return !wr;
      2: return !wr || network_path;
      4: return network_path && !wr;
      5: return network_path;
      default: return !wr || !network_path;
    endcase
  endfunction

  // Watchdog far beyond the expected run length.
  initial begin
    #400000;
    n_mismatch++;
    summarize();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    apb(0, `PAG_OFF_STATUS, 0);
    check(rd, 0, "status reset");
    apb(0, `PAG_OFF_LEVEL, 0);
    check(rd, 32'h0000_270F, "level reset");
    apb(0, 12'h010, 0);
    check(er, 1, "unmapped");
    rq(0, 1, `PAG_P_PWD, 14'h04D2);
    check(g, 0, "password while unset");
    foreach (excl[i]) begin
      rq(0, 1, `PAG_P_GREG, excl[i]);
      check(g, 0, "excluded number");
    end
    repeat (16) begin
      grp.push_back(fresh());
      rq(0, 1, `PAG_P_GREG, grp[$]);
      check(g, 1, "register");
    end
    cnt();
    rq(1, 1, `PAG_P_GREG, fresh());
    check(g, 0, "group full");
    // User group read selection restricts the panel.
    rq(0, 1, `PAG_P_GSEL, 1);
    rq(0, 0, grp[3], 0);
    check(g, 1, "member read");
    rq(0, 0, fresh(), 0);
    check(g, 0, "outsider read");
    rq(0, 0, `PAG_P_WSEL, 0);
    check(g, 1, "selection read");
    rq(0, 1, `PAG_P_GSEL, 0);
    rq(0, 1, `PAG_P_GREM, grp[5]);
    grp.delete(5);
    cnt();
    rq(1, 0, `PAG_P_GREM, 0);
    check(v, `PAG_V_NONE, "removal read");
    rq(0, 1, `PAG_P_GCNT, 5);
    cnt();
    rq(0, 1, `PAG_P_GCNT, `PAG_V_NONE);
    grp.delete();
    cnt();
    // Each strict level 101 to 106 against panel and network, read and write.
    for (int k = 1; k <= 6; k++) begin
      rq(0, 1, `PAG_P_LEVEL, 100 + k);
      rq(1, 1, `PAG_P_PWD, 14'h04D2);
      check(lock_active, 1, "locked");
      for (int a = 0; a < 4; a++) begin
        rq(a[1], a[0], {$random(seed)} % 20, 0);
        check(g, perm(k, a[1], a[0]), "level table");
      end
      rq(0, 0, `PAG_P_LEVEL, 0);
      check(g, 1, "level read");
      rq(0, 1, `PAG_P_PWD, 14'h04D2);
      check(lock_active, 0, "unlock");
    end
    // Lockout after five errors while the drive runs.
    rq(0, 1, `PAG_P_LEVEL, 101);
    rq(0, 1, `PAG_P_PWD, 14'h04D2);
    apb(1, `PAG_OFF_CTRL, 32'h0000_0001);
    rq(0, 1, `PAG_P_PWD, 0);
    check(g, 1, "zero code");
    errs = 0;
    repeat (6) begin
      rq(1, 1, `PAG_P_PWD, 14'h07D0);
      check(e, 1, "wrong code");
      if (errs < 5) errs++;
      rq(0, 0, `PAG_P_PWD, 0);
      check(v, errs, "error count");
    end
    rq(0, 1, `PAG_P_PWD, 14'h04D2);
    check(lock_active, 1, "lockout");
    apb(1, `PAG_OFF_CTRL, 32'h0000_0003);
    apb(0, `PAG_OFF_STATUS, 0);
    check(rd[11], 1, "clear while running");
    apb(1, `PAG_OFF_CTRL, 32'h0000_0000);
    apb(1, `PAG_OFF_CTRL, 32'h0000_0002);
    apb(0, `PAG_OFF_LEVEL, 0);
    check(rd, 32'h0000_270F, "cleared level");
    check(lock_active, 0, "cleared lock");
    // Forbidden levels trip the drive until a full clear.
    foreach (excl[i]) if (i < 2) begin
      rq(0, 1, `PAG_P_LEVEL, i * 100);
      check(option_fault_trip, 1, "fault");
      apb(1, `PAG_OFF_CTRL, 32'h0000_0002);
    end
    summarize();
  end
endmodule
